/* design/rhc_params.svh */
// constants for the reference and holdover control block
`ifndef RHC_PARAMS_SVH
`define RHC_PARAMS_SVH
// register byte offsets
`define RHC_OFF_MODE 12'h000
`define RHC_OFF_HOLD 12'h004
`define RHC_OFF_DAC 12'h008
`define RHC_OFF_LOCK 12'h00C
`define RHC_OFF_DIVS 12'h010
`define RHC_OFF_DIV2 12'h014
`define RHC_OFF_STATUS 12'h018
`define RHC_OFF_PIN 12'h01C
// mode encodings
`define RHC_SEL_AUTO_PRIO 3'h4
`define RHC_SEL_AUTO_PIN 3'h6
`define RHC_HOLD_ENABLED 2'h2
// pin selector choice for holdover status
`define RHC_PINSEL_HOLD 2'h1
// limits of divider settings
`define RHC_L1_DIV_MAX 14'h3FFF
`define RHC_L2_R_MAX 12'hFFF
`define RHC_L2_N_MAX 18'h3FFFF
`define RHC_PRE_MIN 3'h2
`define RHC_PRE_MAX 4'h8
// reset values
`define RHC_RST_DAC_DIV 16'h0004
`define RHC_RST_LOCK_CNT 16'h0010
`define RHC_RST_WINDOW 8'h08
`endif

/* design/rhc_pkg.sv */
// types for the reference and holdover control block
package rhc_pkg;
    typedef enum logic [1:0] {RHC_REF0, RHC_REF1, RHC_REF2} rhc_ref_t;
    typedef enum logic [1:0] {RHC_RUN, RHC_HOLD} rhc_state_t;
endpackage

/* design/rhc_top.sv */
// reference selection, holdover and lock detect with an apb register file
// Contract
// - mode 6 picks reference from select pins
// - pin0 high input0; pin1 high input1; else input2
// - invert both select pins when inversion set
// - entering mode 6 keeps locked reference
// - mode 6 lock loss makes switch event
// - rail crossing enters holdover, raises switch event
// - holdover switch enters holdover, selects from pins
// - priority mode without holdover steps to next input
// - holdover tristates pump, drives fixed or tracked dac
// - holdover needs enable; force bit holds immediately
// - fixed and tracked dac sub-modes supported
// - tracked dac updates every divider detector periods
// - holdover entry on force, lock loss, rail
// - holdover clears loop1 lock, keeps loop2 lock
// - holdover dac uses manual else tracked value
// - holdover status routable to either status pin
// - holdover ends on disable or auto exit
// - auto exit needs window hits for lock count
// - lock counts in-window hits, one miss drops
// - divider fields hold documented maximum ranges
// - priority order input0, input1, input2
`timescale 1ns/1ps
`include "rhc_params.svh"
module rhc_top
    import rhc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic select_pin_0_in,
    input wire logic select_pin_1_in,
    input wire logic pd1_tick_in,
    input wire logic pd1_in_window_in,
    input wire logic pd2_tick_in,
    input wire logic pd2_in_window_in,
    input wire logic [9:0] tune_level_in,
    output logic [1:0] active_ref_out,
    output logic loop1_lock_flag_out,
    output logic loop2_lock_flag_out,
    output logic holdover_out,
    output logic pump_tristate_out,
    output logic [9:0] loop1_tune_output_out,
    output logic lock_status_pin_out,
    output logic holdover_status_pin_out
);
    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [2:0] input_select_mode;
    logic select_pin_invert;
    logic [2:0] ref_enable;
    logic [1:0] holdover_mode;
    logic force_holdover;
    logic lock_loss_ignore;
    logic rail_detect_on;
    logic track_enable;
    logic manual_dac_enable;
    logic [9:0] manual_dac_value;
    logic [9:0] rail_high_threshold;
    logic [9:0] rail_low_threshold;
    logic [15:0] dac_update_div;
    logic [7:0] lock_window_size;
    logic [15:0] lock_count_target;
    logic [13:0] loop1_r_div;
    logic [13:0] loop1_n_div;
    logic [11:0] loop2_r_div;
    logic [17:0] loop2_n_div;
    logic [2:0] loop2_prescale;
    logic [1:0] lock_pin_selector;
    logic [1:0] hold_pin_selector;
    logic ref_doubler_enable;
    // block state
    rhc_ref_t active_ref;
    rhc_state_t state;
    logic [15:0] lock1_count;
    logic [15:0] lock2_count;
    logic lock1;
    logic lock2;
    logic lock1_d;
    logic lock2_at_entry;
    logic [15:0] dac_div_count;
    logic [9:0] dac_count_readback;
    logic switch_armed;
    logic [2:0] mode_d;
    logic enter_hold;
    ////////////////////////////////////////////////////////////////////////////
    // apb decode, zero wait states
    wire apb_access = psel_in && penable_in;
    wire apb_write = apb_access && pwrite_in;
    wire hit_mode = (paddr_in == `RHC_OFF_MODE);
    wire hit_hold = (paddr_in == `RHC_OFF_HOLD);
    wire hit_dac = (paddr_in == `RHC_OFF_DAC);
    wire hit_lock = (paddr_in == `RHC_OFF_LOCK);
    wire hit_divs = (paddr_in == `RHC_OFF_DIVS);
    wire hit_div2 = (paddr_in == `RHC_OFF_DIV2);
    wire hit_status = (paddr_in == `RHC_OFF_STATUS);
    wire hit_pin = (paddr_in == `RHC_OFF_PIN);
    wire hit_any = hit_mode || hit_hold || hit_dac || hit_lock || hit_divs || hit_div2
                   || hit_status || hit_pin;
    logic [31:0] next_prdata;
    always_comb begin
        if (hit_mode) begin
            next_prdata = {24'h0, ref_enable, select_pin_invert, 1'b0, input_select_mode};
        end else if (hit_hold) begin
            next_prdata = {24'h0, 1'b0, manual_dac_enable, track_enable, rail_detect_on,
                           lock_loss_ignore, force_holdover, holdover_mode};
        end else if (hit_dac) begin
            next_prdata = {2'h0, rail_high_threshold, rail_low_threshold, manual_dac_value};
        end else if (hit_lock) begin
            next_prdata = {lock_count_target, 8'h0, lock_window_size};
        end else if (hit_divs) begin
            next_prdata = {2'h0, loop1_n_div, 2'h0, loop1_r_div};
        end else if (hit_div2) begin
            next_prdata = {ref_doubler_enable, loop2_prescale, 1'b0,
                           loop2_n_div, 9'h000};
        end else if (hit_status) begin
            next_prdata = {16'h0, dac_count_readback, lock2, lock1,
                           (state == RHC_HOLD), 1'b0, active_ref};
        end else if (hit_pin) begin
            next_prdata = {dac_update_div, 12'h0, hold_pin_selector, lock_pin_selector};
        end else begin
            next_prdata = 32'h0;
        end
    end
    // loop-2 r divider is write only; its field shares bits 19:16 with the count target
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prdata_out <= 32'h0;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            prdata_out <= (psel_in && !penable_in && !pwrite_in) ? next_prdata : 32'h0;
            pready_out <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !hit_any;
        end
    end
    wire wr_ok = apb_write && pready_out;
    // prescaler field 0 stands for a divide by 8; 1 is raised to the minimum of 2
    wire [2:0] pre_w = (pwdata_in[30:28] == 3'h1) ? `RHC_PRE_MIN : pwdata_in[30:28];
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            input_select_mode <= 3'h0;
            select_pin_invert <= 1'b0;
            ref_enable <= 3'h7;
            holdover_mode <= 2'h0;
            lock_loss_ignore <= 1'b0;
            rail_detect_on <= 1'b0;
            track_enable <= 1'b0;
            manual_dac_enable <= 1'b0;
            manual_dac_value <= 10'h200;
            rail_high_threshold <= 10'h3C0;
            rail_low_threshold <= 10'h040;
            lock_window_size <= `RHC_RST_WINDOW;
            lock_count_target <= `RHC_RST_LOCK_CNT;
            loop1_r_div <= 14'h0001;
            loop1_n_div <= 14'h0001;
            loop2_r_div <= 12'h001;
            loop2_n_div <= 18'h00001;
            loop2_prescale <= `RHC_PRE_MIN;
            ref_doubler_enable <= 1'b0;
            dac_update_div <= `RHC_RST_DAC_DIV;
            lock_pin_selector <= 2'h0;
            hold_pin_selector <= `RHC_PINSEL_HOLD;
        end else if (wr_ok) begin
            if (hit_mode) begin
                input_select_mode <= pwdata_in[2:0];
                select_pin_invert <= pwdata_in[4];
                ref_enable <= pwdata_in[7:5];
            end else if (hit_hold) begin
                holdover_mode <= pwdata_in[1:0];
                lock_loss_ignore <= pwdata_in[3];
                rail_detect_on <= pwdata_in[4];
                // tracked sub-mode is refused with rail detection unless the manual dac is also enabled
                track_enable <= pwdata_in[5] && !(pwdata_in[4] && !pwdata_in[6]);
                manual_dac_enable <= pwdata_in[6];
            end else if (hit_dac) begin
                manual_dac_value <= pwdata_in[9:0];
                rail_low_threshold <= pwdata_in[19:10];
                rail_high_threshold <= pwdata_in[29:20];
            end else if (hit_lock) begin
                lock_window_size <= pwdata_in[7:0];
                lock_count_target <= pwdata_in[31:16];
                loop2_r_div <= pwdata_in[19:8];
            end else if (hit_divs) begin
                loop1_r_div <= pwdata_in[13:0];
                loop1_n_div <= pwdata_in[29:16];
            end else if (hit_div2) begin
                loop2_n_div <= pwdata_in[26:9];
                loop2_prescale <= pre_w;
                ref_doubler_enable <= pwdata_in[31];
            end else if (hit_pin) begin
                lock_pin_selector <= pwdata_in[1:0];
                hold_pin_selector <= pwdata_in[3:2];
                dac_update_div <= pwdata_in[31:16];
            end
        end
    end
    // force bit is a level: it holds the block in holdover until software clears it
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            force_holdover <= 1'b0;
        end else if (wr_ok && hit_hold) begin
            force_holdover <= pwdata_in[2];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // lock detectors
    wire lock1_hit = pd1_tick_in && pd1_in_window_in;
    wire lock1_miss = pd1_tick_in && !pd1_in_window_in;
    wire lock2_hit = pd2_tick_in && pd2_in_window_in;
    wire lock2_miss = pd2_tick_in && !pd2_in_window_in;
    wire lock1_reach = lock1_hit && (lock1_count + 16'h1 >= lock_count_target);
    wire lock2_reach = lock2_hit && (lock2_count + 16'h1 >= lock_count_target);
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            lock1_count <= 16'h0;
            lock2_count <= 16'h0;
            lock1 <= 1'b0;
            lock2 <= 1'b0;
        end else begin
            if (lock1_miss) begin
                lock1_count <= 16'h0;
                lock1 <= 1'b0;
            end else if (enter_hold) begin
                lock1_count <= 16'h0;
            end else if (lock1_hit) begin
                lock1_count <= lock1_reach ? lock1_count : lock1_count + 16'h1;
                lock1 <= lock1 || lock1_reach;
            end
            if (lock2_miss) begin
                lock2_count <= 16'h0;
                lock2 <= 1'b0;
            end else if (lock2_hit) begin
                lock2_count <= lock2_reach ? lock2_count : lock2_count + 16'h1;
                lock2 <= lock2 || lock2_reach;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // switching and holdover
    wire in_hold = (state == RHC_HOLD);
    wire hold_en = (holdover_mode == `RHC_HOLD_ENABLED);
    wire pin0 = select_pin_0_in ^ select_pin_invert;
    wire pin1 = select_pin_1_in ^ select_pin_invert;
    wire rhc_ref_t pin_ref = pin0 ? RHC_REF0 : (pin1 ? RHC_REF1 : RHC_REF2);
    // next enabled input after the active one, wrapping 0,1,2
    wire [1:0] a = active_ref;
    wire [1:0] s1 = (a == 2'h2) ? 2'h0 : a + 2'h1;
    wire [1:0] s2 = (s1 == 2'h2) ? 2'h0 : s1 + 2'h1;
    wire rhc_ref_t prio_ref = ref_enable[s1] ? rhc_ref_t'(s1)
                            : (ref_enable[s2] ? rhc_ref_t'(s2) : active_ref);
    wire auto_pin = (input_select_mode == `RHC_SEL_AUTO_PIN);
    wire auto_prio = (input_select_mode == `RHC_SEL_AUTO_PRIO);
    wire rail_cross = (tune_level_in > rail_high_threshold)
                      || (tune_level_in < rail_low_threshold);
    wire rail_trip = hold_en && rail_detect_on && track_enable && manual_dac_enable
                     && rail_cross;
    wire lock_fall = lock1_d && !lock1;
    // the flag must rise again before another event; the arm bit enforces it
    wire switch_event = switch_armed && (auto_pin || auto_prio)
                        && (lock_fall || rail_trip) && !lock_loss_ignore;
    assign enter_hold = !in_hold && (force_holdover
                      || (hold_en && !lock_loss_ignore && lock_fall) || rail_trip);
    // auto exit once the detector has seen the full run on the active input
    wire exit_hold = in_hold && !force_holdover && (!hold_en || lock1_reach);
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state <= RHC_RUN;
            active_ref <= RHC_REF0;
            lock1_d <= 1'b0;
            lock2_at_entry <= 1'b0;
            switch_armed <= 1'b1;
            mode_d <= 3'h0;
        end else begin
            lock1_d <= lock1;
            mode_d <= input_select_mode;
            case (state)
                RHC_RUN: begin
                    if (enter_hold) begin
                        state <= RHC_HOLD;
                        lock2_at_entry <= lock2;
                    end
                end
                RHC_HOLD: begin
                    if (exit_hold) begin
                        state <= RHC_RUN;
                    end
                end
                default: state <= RHC_RUN;
            endcase
            if (input_select_mode < 3'h3) begin
                active_ref <= rhc_ref_t'(input_select_mode[1:0]);
            end else if (auto_pin && mode_d != input_select_mode && !lock1) begin
                active_ref <= pin_ref;
            end else if (switch_event) begin
                active_ref <= auto_pin ? pin_ref : prio_ref;
            end
            if (switch_event) begin
                switch_armed <= 1'b0;
            end else if (lock1 && !in_hold) begin
                switch_armed <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // dac tracking and outputs
    wire dac_tick = pd1_tick_in && (dac_div_count + 16'h1 >= dac_update_div);
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            dac_div_count <= 16'h0;
            dac_count_readback <= 10'h0;
        end else if (track_enable && pd1_tick_in) begin
            dac_div_count <= dac_tick ? 16'h0 : dac_div_count + 16'h1;
            if (dac_tick && !in_hold) begin
                dac_count_readback <= tune_level_in;
            end
        end
    end
    wire [9:0] hold_dac = manual_dac_enable ? manual_dac_value : dac_count_readback;
    wire hold_next = in_hold ? !exit_hold : enter_hold;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            active_ref_out <= 2'h0;
            loop1_lock_flag_out <= 1'b0;
            loop2_lock_flag_out <= 1'b0;
            holdover_out <= 1'b0;
            pump_tristate_out <= 1'b0;
            loop1_tune_output_out <= 10'h0;
            lock_status_pin_out <= 1'b0;
            holdover_status_pin_out <= 1'b0;
        end else begin
            active_ref_out <= active_ref;
            loop1_lock_flag_out <= lock1 && !in_hold;
            loop2_lock_flag_out <= in_hold ? (lock2_at_entry || lock2) : lock2;
            holdover_out <= in_hold;
            pump_tristate_out <= hold_next;
            loop1_tune_output_out <= hold_next ? hold_dac : tune_level_in;
            lock_status_pin_out <= (lock_pin_selector == `RHC_PINSEL_HOLD)
                                   ? in_hold : (lock1 && !in_hold);
            holdover_status_pin_out <= (hold_pin_selector == `RHC_PINSEL_HOLD)
                                       ? in_hold : (lock1 && lock2);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_pin_decode;
        @(posedge clk_in) disable iff (reset_in)
        (switch_event && auto_pin && input_select_mode == $past(input_select_mode))
        |=> (active_ref == $past(pin_ref));
    endproperty
    a_pin_decode: assert property (p_pin_decode) else $error("pin decode wrong");
    property p_prio_step;
        @(posedge clk_in) disable iff (reset_in)
        (switch_event && auto_prio) |=> (active_ref == $past(prio_ref));
    endproperty
    a_prio_step: assert property (p_prio_step) else $error("priority step wrong");
    property p_miss_clears;
        @(posedge clk_in) disable iff (reset_in)
        lock1_miss |=> (lock1_count == 16'h0) && !lock1;
    endproperty
    a_miss_clears: assert property (p_miss_clears) else $error("miss kept lock");
    property p_hold_flags;
        @(posedge clk_in) disable iff (reset_in)
        in_hold |=> (holdover_out && !loop1_lock_flag_out);
    endproperty
    a_hold_flags: assert property (p_hold_flags) else $error("holdover flags wrong");
    property p_force;
        @(posedge clk_in) disable iff (reset_in)
        (force_holdover && !in_hold) |=> in_hold ##1 pump_tristate_out;
    endproperty
    a_force: assert property (p_force) else $error("force did not hold");
    property p_hold_dac;
        @(posedge clk_in) disable iff (reset_in)
        (in_hold && !exit_hold) |=> (loop1_tune_output_out == $past(hold_dac));
    endproperty
    a_hold_dac: assert property (p_hold_dac) else $error("holdover dac wrong");
    property p_disable_exit;
        @(posedge clk_in) disable iff (reset_in)
        (in_hold && !hold_en && !force_holdover) |=> !in_hold;
    endproperty
    a_disable_exit: assert property (p_disable_exit) else $error("no exit");
    property p_rearm;
        @(posedge clk_in) disable iff (reset_in)
        (!switch_armed && !lock1) |=> !switch_event;
    endproperty
    a_rearm: assert property (p_rearm) else $error("event without relock");
endmodule

/* dv/rhc_host_model.sv */
// host-side model: select pins and phase comparator activity
`timescale 1ns/1ps
module rhc_host_model (
    input wire logic clk_in,
    input wire logic [1:0] pins_in,
    input wire logic good_in,
    output logic select_pin_0_out,
    output logic select_pin_1_out,
    output logic pd_tick_out,
    output logic pd1_win_out,
    output logic pd2_win_out,
    output logic [9:0] tune_out
);
    initial begin
        pd_tick_out = 1'b0;
        pd1_win_out = 1'b0;
        pd2_win_out = 1'b0;
        {select_pin_1_out, select_pin_0_out} = 2'h0;
        tune_out = 10'h1C3;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one comparison every second cycle keeps the detector rate low
    always @(posedge clk_in) begin
        pd_tick_out <= ~pd_tick_out;
        // between comparisons the window line carries junk, not the last verdict
        pd1_win_out <= pd_tick_out ? ~good_in : good_in;
        pd2_win_out <= ~pd_tick_out;
        {select_pin_1_out, select_pin_0_out} <= pins_in;
        tune_out <= 10'h1C3;
    end
endmodule

/* dv/rhc_tb_top.sv */
// self-checking bench for the reference and holdover control block
`timescale 1ns/1ps
`include "rhc_params.svh"
module rhc_tb_top;
    import rhc_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, serr, sp0, sp1, tick, w1, w2, good = 1'b0;
    logic [1:0] pins = 2'h0, act, eff;
    logic [9:0] tune, tout;
    logic lk1, lk2, hold, pump, lpin, hpin;
    int errors = 0;
    int n_tests = 0;
    int h, i, e;
    always #10 clk_in = ~clk_in;
    rhc_top dut (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .select_pin_0_in(sp0),
        .select_pin_1_in(sp1), .pd1_tick_in(tick), .pd1_in_window_in(w1), .pd2_tick_in(tick),
        .pd2_in_window_in(w2), .tune_level_in(tune), .active_ref_out(act),
        .loop1_lock_flag_out(lk1), .loop2_lock_flag_out(lk2), .holdover_out(hold),
        .pump_tristate_out(pump), .loop1_tune_output_out(tout), .lock_status_pin_out(lpin),
        .holdover_status_pin_out(hpin));
    rhc_host_model host (.clk_in(clk_in), .pins_in(pins), .good_in(good),
        .select_pin_0_out(sp0), .select_pin_1_out(sp1), .pd_tick_out(tick),
        .pd1_win_out(w1), .pd2_win_out(w2), .tune_out(tune));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_in);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            errors++;
            results();
        end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    // drop the window until a comparison misses and the registered flags follow
    task automatic miss;
        good <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask
    // counts in-window comparisons until lock rises, or holdover ends when ho is set
    task automatic relock(input bit ho, output int hits);
        int k;
        hits = 0;
        good <= 1'b1;
        for (k = 0; k < 300; k++) begin
            @(posedge clk_in);
            if (ho ? hold === 1'b0 : lk1 === 1'b1) break;
            if (tick === 1'b1 && w1 === 1'b1) hits++;
        end
        if (k == 300) begin
            errors++;
            results();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        apb(1'b0, `RHC_OFF_MODE, 32'h0);
        chk("mode reset", rd, 32'h000000E0);
        apb(1'b0, `RHC_OFF_PIN, 32'h0);
        chk("pin reset", rd, 32'h00040004);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", 32'(serr), 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, `RHC_OFF_DIVS, 32'h3FFF3FFF);
        apb(1'b0, `RHC_OFF_DIVS, 32'h0);
        chk("loop1 dividers", rd, 32'h3FFF3FFF);
        apb(1'b1, `RHC_OFF_DIV2, 32'h97FFFE00);
        apb(1'b0, `RHC_OFF_DIV2, 32'h0);
        chk("loop2 dividers", rd, 32'hA7FFFE00);
        $display("test registers done");
        relock(1'b0, h);
        chk("hits to lock", 32'(h), 32'h10);
        chk("lock pin", 32'(lpin), 32'h1);
        miss();
        chk("lock after miss", 32'(lk1), 32'h0);
        relock(1'b0, h);
        chk("hits after miss", 32'(h), 32'h10);
        $display("test lock detect done");
        // manual input 0 is locked, so the switch to pin mode keeps it
        apb(1'b1, `RHC_OFF_MODE, 32'h000000E6);
        repeat (2) @(posedge clk_in);
        chk("entry keeps ref", 32'(act), 32'h0);
        for (i = 0; i < 8; i++) begin
            pins <= i[1:0];
            apb(1'b1, `RHC_OFF_MODE, {24'h0, 3'h7, i[2], 1'b0, 3'h6});
            miss();
            chk("no holdover when off", 32'(hold), 32'h0);
            relock(1'b0, h);
            eff = i[1:0] ^ {2{i[2]}};
            e = eff[0] ? 0 : (eff[1] ? 1 : 2);
            chk("pin selected ref", 32'(act), 32'(e));
        end
        $display("test pin selection done");
        pins <= 2'b10;
        apb(1'b1, `RHC_OFF_MODE, 32'h000000E6);
        apb(1'b1, `RHC_OFF_DAC, 32'h000002A5);
        apb(1'b1, `RHC_OFF_HOLD, 32'h00000042);
        apb(1'b1, `RHC_OFF_PIN, 32'h00040005);
        miss();
        chk("holdover entered", 32'(hold), 32'h1);
        chk("pump tristate", 32'(pump), 32'h1);
        chk("lock1 in holdover", 32'(lk1), 32'h0);
        chk("lock2 in holdover", 32'(lk2), 32'h1);
        chk("holdover dac", 32'(tout), 32'h2A5);
        chk("holdover ref", 32'(act), 32'h1);
        chk("holdover pin", 32'(hpin), 32'h1);
        chk("lock pin holdover", 32'(lpin), 32'h1);
        relock(1'b1, h);
        chk("hits to exit", 32'(h), 32'h10);
        repeat (2) @(posedge clk_in);
        chk("tune after exit", 32'(tout), 32'h1C3);
        apb(1'b1, `RHC_OFF_HOLD, 32'h00000046);
        repeat (2) @(posedge clk_in);
        chk("forced holdover", 32'(hold), 32'h1);
        apb(1'b1, `RHC_OFF_HOLD, 32'h0);
        repeat (2) @(posedge clk_in);
        chk("disabled exits", 32'(hold), 32'h0);
        $display("test holdover done");
        apb(1'b1, `RHC_OFF_MODE, 32'h000000E0);
        relock(1'b0, h);
        apb(1'b1, `RHC_OFF_MODE, 32'h000000E4);
        for (i = 1; i < 4; i++) begin
            miss();
            relock(1'b0, h);
            chk("priority ref", 32'(act), 32'(i % 3));
        end
        $display("test priority done");
        // a 25 MHz comparison rate over a divider of 250 gives a 100 kHz update rate
        apb(1'b1, `RHC_OFF_PIN, 32'h00FA0004);
        apb(1'b1, `RHC_OFF_DAC, 32'h3C0102A5);
        apb(1'b1, `RHC_OFF_HOLD, 32'h00000072);
        repeat (520) @(posedge clk_in);
        apb(1'b0, `RHC_OFF_STATUS, 32'h0);
        chk("tracked dac", 32'(rd[15:6]), 32'h1C3);
        apb(1'b1, `RHC_OFF_DAC, 32'h100102A5);
        repeat (2) @(posedge clk_in);
        chk("rail holdover", 32'(hold), 32'h1);
        chk("rail switch", 32'(act), 32'h1);
        chk("manual over tracked", 32'(tout), 32'h2A5);
        $display("test rail and tracking done");
        results();
    end
endmodule
